/* bsf_execute.sv */
// bsf_execute: one-cycle bit, shift and flag execution datapath with apb status access
//
// Operation
// RULE_01 - rotate left via carry; swap nibbles, flags kept
// RULE_02 - rotate right via carry; arithmetic shift keeps bit7
// RULE_03 - io bit set forces selected bit high
// RULE_04 - io bit clear forces selected bit low
// RULE_05 - bit store copies register bit into T
// RULE_06 - bit load copies T into register bit
// RULE_07 - flag set writes one to one bit
// RULE_08 - flag clear writes zero; I clear masks irqs
// RULE_09 - overflow set/clear touches only V
// RULE_10 - control ops take one cycle, no flags
`timescale 1ns/1ps
module bsf_execute
    import bsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire bsf_req_t issue_req,
    input wire bsf_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] res_data,
    output logic res_we,
    output logic [7:0] io_wdata,
    output logic [4:0] io_waddr,
    output logic io_we,
    output logic [7:0] status_flags,
    output logic irq_accept_en,
    output logic op_done
);
    bsf_state_t s_reg;
    bsf_state_t s_next;
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] f;
    logic apb_wr;

    // next state: apb slave first, then the issued instruction
    always_comb begin
        s_next = s_reg;
        d = issue_req.rd_data;
        r = 8'h00;
        f = s_reg.status_flags;
        apb_wr = apb_req.psel && apb_req.penable && s_reg.pready && apb_req.pwrite;
        s_next.res_we = 1'b0;
        s_next.io_we = 1'b0;
        s_next.done = 1'b0;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        // setup cycle captures read data so the access phase answers from flops
        if (apb_req.psel && !apb_req.penable) begin
            s_next.pready = 1'b1;
            unique case (apb_req.paddr)
                BSF_OFF_STATUS: s_next.prdata = {24'h000000, s_reg.status_flags};
                BSF_OFF_COUNT: s_next.prdata = {16'h0000, s_reg.issue_count};
                default: begin
                    s_next.prdata = 32'h00000000;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_wr && apb_req.paddr == BSF_OFF_STATUS) begin
            f = apb_req.pwdata[7:0];
        end
        if (issue_req.valid) begin
            s_next.done = 1'b1; // RULE_10
            s_next.issue_count = s_reg.issue_count + 16'h0001;
            // flags are computed from the pre-write flags; a same-cycle op wins
            f = s_reg.status_flags;
            unique case (issue_req.op)
                BSF_ROTATE_LEFT_CARRY_OP: begin
                    r = {d[6:0], s_reg.status_flags[BSF_FLAG_C]}; // RULE_01
                    f[BSF_FLAG_C] = d[7]; // RULE_01
                    f[BSF_FLAG_H] = d[3]; // RULE_01
                end
                BSF_ROTATE_RIGHT_CARRY_OP: begin
                    r = {s_reg.status_flags[BSF_FLAG_C], d[7:1]}; // RULE_02
                    f[BSF_FLAG_C] = d[0]; // RULE_02
                end
                BSF_ARITH_RIGHT_SHIFT_OP: begin
                    r = {d[7], d[7:1]}; // RULE_02
                    f[BSF_FLAG_C] = d[0]; // RULE_02
                end
                BSF_NIBBLE_SWAP_OP: r = {d[3:0], d[7:4]}; // RULE_01
                BSF_IO_BIT_SET_OP: r = issue_req.io_data | (8'h01 << issue_req.bit_sel); // RULE_03
                BSF_IO_BIT_CLEAR_OP: r = issue_req.io_data & ~(8'h01 << issue_req.bit_sel); // RULE_04
                BSF_BIT_TO_FLAG_OP: f[BSF_FLAG_T] = d[issue_req.bit_sel]; // RULE_05
                BSF_FLAG_TO_BIT_OP: begin
                    r = d; // RULE_06
                    r[issue_req.bit_sel] = s_reg.status_flags[BSF_FLAG_T]; // RULE_06
                end
                BSF_INDEXED_FLAG_SET_OP: f[issue_req.bit_sel] = 1'b1; // RULE_07 RULE_09
                BSF_INDEXED_FLAG_CLEAR_OP: f[issue_req.bit_sel] = 1'b0; // RULE_08 RULE_09
                BSF_GLOBAL_IRQ_ENABLE_OP: f[BSF_FLAG_I] = 1'b1; // RULE_07
                BSF_GLOBAL_IRQ_DISABLE_OP: f[BSF_FLAG_I] = 1'b0; // RULE_08
                BSF_NOP, BSF_BREAK_OP, BSF_SLEEP_OP, BSF_WATCHDOG_KICK_OP: r = 8'h00; // RULE_10
            endcase
            // shared shift flags: n from result, v = n ^ c, s = n ^ v
            if (issue_req.op == BSF_ROTATE_LEFT_CARRY_OP || issue_req.op == BSF_ROTATE_RIGHT_CARRY_OP ||
                issue_req.op == BSF_ARITH_RIGHT_SHIFT_OP) begin
                f[BSF_FLAG_Z] = (r == 8'h00); // RULE_01 RULE_02
                f[BSF_FLAG_N] = r[7];
                f[BSF_FLAG_V] = r[7] ^ f[BSF_FLAG_C];
                f[BSF_FLAG_S] = r[7] ^ (r[7] ^ f[BSF_FLAG_C]);
            end
            s_next.res_data = r;
            s_next.res_we = (issue_req.op inside {BSF_ROTATE_LEFT_CARRY_OP, BSF_ROTATE_RIGHT_CARRY_OP,
                BSF_ARITH_RIGHT_SHIFT_OP, BSF_NIBBLE_SWAP_OP, BSF_FLAG_TO_BIT_OP});
            s_next.io_we = (issue_req.op inside {BSF_IO_BIT_SET_OP, BSF_IO_BIT_CLEAR_OP});
            s_next.io_wdata = r;
            s_next.io_waddr = issue_req.io_addr;
        end
        s_next.status_flags = f;
    end

    // state register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.status_flags <= BSF_STATUS_RST;
            s_reg.issue_count <= BSF_COUNT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from state flops
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign res_data = s_reg.res_data;
    assign res_we = s_reg.res_we;
    assign io_wdata = s_reg.io_wdata;
    assign io_waddr = s_reg.io_waddr;
    assign io_we = s_reg.io_we;
    assign status_flags = s_reg.status_flags;
    assign irq_accept_en = s_reg.status_flags[BSF_FLAG_I]; // RULE_08
    assign op_done = s_reg.done;

    // helper copies for the checks below
    bsf_req_t q_req;
    logic [7:0] q_f;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_req <= '0;
            q_f <= BSF_STATUS_RST;
        end else begin
            q_req <= issue_req;
            q_f <= s_reg.status_flags;
        end
    end

    sequence s_issued(bsf_op_t o);
        issue_req.valid && issue_req.op == o ##1 op_done;
    endsequence

    property p_rol;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_ROTATE_LEFT_CARRY_OP) |-> res_we && res_data == {q_req.rd_data[6:0], q_f[0]}
            && status_flags[0] == q_req.rd_data[7] && status_flags[5] == q_req.rd_data[3];
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left result or flags wrong"); // RULE_01

    property p_swap;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_NIBBLE_SWAP_OP) |-> res_data == {q_req.rd_data[3:0], q_req.rd_data[7:4]}
            && status_flags == q_f;
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong or flags touched"); // RULE_01

    property p_shr;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_ARITH_RIGHT_SHIFT_OP) or s_issued(BSF_ROTATE_RIGHT_CARRY_OP) |->
            res_data[6:0] == q_req.rd_data[7:1] && status_flags[0] == q_req.rd_data[0]
            && status_flags[1] == (res_data == 8'h00) && status_flags[3] == (res_data[7] ^ q_req.rd_data[0]);
    endproperty
    a_shr: assert property (p_shr) else $error("right shift result or flags wrong"); // RULE_02

    property p_sbi;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_IO_BIT_SET_OP) |-> io_we && io_wdata[q_req.bit_sel] && status_flags == q_f
            && (io_wdata | (8'h01 << q_req.bit_sel)) == (q_req.io_data | (8'h01 << q_req.bit_sel));
    endproperty
    a_sbi: assert property (p_sbi) else $error("io bit set wrong"); // RULE_03

    property p_cbi;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_IO_BIT_CLEAR_OP) |-> io_we && !io_wdata[q_req.bit_sel] && status_flags == q_f
            && io_waddr == q_req.io_addr
            && (io_wdata & ~(8'h01 << q_req.bit_sel)) == (q_req.io_data & ~(8'h01 << q_req.bit_sel));
    endproperty
    a_cbi: assert property (p_cbi) else $error("io bit clear wrong"); // RULE_04

    property p_bst;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_BIT_TO_FLAG_OP) |-> status_flags[6] == q_req.rd_data[q_req.bit_sel]
            && status_flags[5:0] == q_f[5:0] && status_flags[7] == q_f[7] && !res_we;
    endproperty
    a_bst: assert property (p_bst) else $error("bit store into T wrong"); // RULE_05

    property p_bld;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_FLAG_TO_BIT_OP) |-> res_we && res_data[q_req.bit_sel] == q_f[6] && status_flags == q_f;
    endproperty
    a_bld: assert property (p_bld) else $error("bit load from T wrong"); // RULE_06

    property p_indexed_flag_set_op;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_INDEXED_FLAG_SET_OP) |-> status_flags == (q_f | (8'h01 << q_req.bit_sel));
    endproperty
    a_indexed_flag_set_op: assert property (p_indexed_flag_set_op) else $error("flag set touched wrong bits"); // RULE_07 RULE_09

    property p_indexed_flag_clear_op;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_INDEXED_FLAG_CLEAR_OP) |-> status_flags == (q_f & ~(8'h01 << q_req.bit_sel));
    endproperty
    a_indexed_flag_clear_op: assert property (p_indexed_flag_clear_op) else $error("flag clear touched wrong bits"); // RULE_08 RULE_09

    property p_cli;
        @(posedge core_clk) disable iff (sys_rst)
        s_issued(BSF_GLOBAL_IRQ_DISABLE_OP) |-> !irq_accept_en && status_flags[6:0] == q_f[6:0];
    endproperty
    a_cli: assert property (p_cli) else $error("irq disable did not mask"); // RULE_08

    property p_ctrl;
        @(posedge core_clk) disable iff (sys_rst)
        issue_req.valid && issue_req.op inside {BSF_NOP, BSF_BREAK_OP, BSF_SLEEP_OP, BSF_WATCHDOG_KICK_OP}
            ##1 op_done |-> status_flags == q_f && !res_we && !io_we;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control op changed state"); // RULE_10
endmodule : bsf_execute

/* bsf_pkg.sv */
// package: constants, opcodes and carriers for the bit/shift/flag datapath
package bsf_pkg;
    // apb register byte offsets
    localparam logic [11:0] BSF_OFF_STATUS = 12'h000;
    localparam logic [11:0] BSF_OFF_COUNT = 12'h004;
    // values after reset
    localparam logic [7:0] BSF_STATUS_RST = 8'h00;
    localparam logic [15:0] BSF_COUNT_RST = 16'h0000;
    // status flag bit positions
    localparam int BSF_FLAG_C = 0;
    localparam int BSF_FLAG_Z = 1;
    localparam int BSF_FLAG_N = 2;
    localparam int BSF_FLAG_V = 3;
    localparam int BSF_FLAG_S = 4;
    localparam int BSF_FLAG_H = 5;
    localparam int BSF_FLAG_T = 6;
    localparam int BSF_FLAG_I = 7;
    // latency of every operation in cycles
    localparam int BSF_OP_CYCLES = 1;

    typedef enum logic [3:0] {
        BSF_NOP = 4'h0,
        BSF_ROTATE_LEFT_CARRY_OP = 4'h1,
        BSF_ROTATE_RIGHT_CARRY_OP = 4'h2,
        BSF_ARITH_RIGHT_SHIFT_OP = 4'h3,
        BSF_NIBBLE_SWAP_OP = 4'h4,
        BSF_IO_BIT_SET_OP = 4'h5,
        BSF_IO_BIT_CLEAR_OP = 4'h6,
        BSF_BIT_TO_FLAG_OP = 4'h7,
        BSF_FLAG_TO_BIT_OP = 4'h8,
        BSF_INDEXED_FLAG_SET_OP = 4'h9,
        BSF_INDEXED_FLAG_CLEAR_OP = 4'ha,
        BSF_BREAK_OP = 4'hb,
        BSF_SLEEP_OP = 4'hc,
        BSF_WATCHDOG_KICK_OP = 4'hd,
        BSF_GLOBAL_IRQ_ENABLE_OP = 4'he,
        BSF_GLOBAL_IRQ_DISABLE_OP = 4'hf
    } bsf_op_t;

    // one issued instruction from the decoder and register file
    typedef struct packed {
        logic valid;
        bsf_op_t op;
        logic [7:0] rd_data;
        logic [7:0] io_data;
        logic [4:0] io_addr;
        logic [2:0] bit_sel;
    } bsf_req_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } bsf_apb_req_t;

    // whole module state
    typedef struct packed {
        logic [7:0] status_flags;
        logic [15:0] issue_count;
        logic [7:0] res_data;
        logic res_we;
        logic [7:0] io_wdata;
        logic [4:0] io_waddr;
        logic io_we;
        logic done;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } bsf_state_t;
endpackage : bsf_pkg

/* bsf_partner.sv */
// decoder and register file model feeding the bit/shift/flag datapath
`timescale 1ns/1ps
module bsf_partner
    import bsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] res_data,
    input wire logic res_we,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    output bsf_req_t issue_req
);
    logic [7:0] gpr_reg = 8'h00;
    logic [7:0] io_reg = 8'h00;
    initial issue_req = '0;
    // write-back lands one edge after the result pulse
    always @(posedge core_clk) begin
        if (res_we) gpr_reg <= res_data;
        if (io_we) io_reg <= io_wdata;
    end
    // one issue cycle; released operands are inverted so stale data never passes
    task automatic issue(input bsf_op_t op, input logic [2:0] b);
        issue_req <= '{valid: 1'b1, op: op, rd_data: gpr_reg, io_data: io_reg, io_addr: 5'h0a, bit_sel: b};
        @(posedge core_clk);
        issue_req.valid <= 1'b0;
        issue_req.rd_data <= ~gpr_reg;
        issue_req.io_data <= ~io_reg;
    endtask : issue
endmodule : bsf_partner

/* bsf_execute_tb.sv */
// self-checking testbench for the bit, shift and flag datapath
`timescale 1ns/1ps
module bsf_execute_tb;
    import bsf_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    bsf_apb_req_t apb_req = '0;
    bsf_req_t issue_req;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, res_we, io_we, irq_accept_en, op_done, err;
    logic [7:0] res_data, io_wdata, status_flags, fl;
    logic [4:0] io_waddr;
    int n_errors = 0;
    int check_count = 0;
    int n_ops = 0;
    always #5 core_clk = ~core_clk;
    bsf_execute bsf_execute_i (.core_clk(core_clk), .sys_rst(sys_rst), .issue_req(issue_req), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .res_data(res_data), .res_we(res_we),
        .io_wdata(io_wdata), .io_waddr(io_waddr), .io_we(io_we), .status_flags(status_flags),
        .irq_accept_en(irq_accept_en), .op_done(op_done));
    bsf_partner bsf_partner_i (.core_clk(core_clk), .res_data(res_data), .res_we(res_we),
        .io_wdata(io_wdata), .io_we(io_we), .issue_req(issue_req));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // apb transfer: setup, then access held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        err = pslverr;
        apb_req <= '0;
        // idle edge, so back-to-back calls never assign the request twice in one step
        @(posedge core_clk);
        if (n >= 20) begin
            n_errors++;
            results;
        end
    endtask : apb
    task automatic wr_flags(input logic [7:0] v);
        apb(1'b1, BSF_OFF_STATUS, {24'h0, v});
        fl = v;
    endtask : wr_flags
    // issue one op, check the one-cycle answer, then let write-back land
    task automatic run_op(input bsf_op_t op, input logic [2:0] b, input logic [7:0] rd, input logic [1:0] we);
        bsf_partner_i.gpr_reg = rd;
        bsf_partner_i.issue(op, b);
        #1;
        chk({op_done, res_we, io_we, status_flags, irq_accept_en}, {1'b1, we, fl, fl[7]});
        n_ops++;
        @(posedge core_clk);
        @(posedge core_clk);
    endtask : run_op
    task automatic t_shift;
        logic [7:0] vals [4] = '{8'h81, 8'h01, 8'h48, 8'hfe};
        logic [7:0] v, r;
        for (int i = 0; i < 8; i++) begin
            for (int k = 1; k < 5; k++) begin
                v = vals[i % 4];
                wr_flags(i[2] ? 8'h61 : 8'h40);
                case (k)
                    1: r = {v[6:0], fl[0]};
                    2: r = {fl[0], v[7:1]};
                    3: r = {v[7], v[7:1]};
                    default: r = {v[3:0], v[7:4]};
                endcase
                if (k < 4) begin
                    fl[0] = (k == 1) ? v[7] : v[0];
                    fl[1] = (r == 8'h00);
                    fl[2] = r[7];
                    fl[3] = r[7] ^ fl[0];
                    fl[4] = fl[2] ^ fl[3];
                    if (k == 1) fl[5] = v[3];
                end
                run_op(bsf_op_t'(k), 3'h0, v, 2'b10);
                chk(res_data, r);
            end
        end
        $display("t_shift done");
    endtask : t_shift
    // set then clear every bit of one io register, chained through the model
    task automatic t_io;
        logic [7:0] e;
        e = 8'h5a;
        bsf_partner_i.io_reg = e;
        for (int k = 0; k < 16; k++) begin
            e[k % 8] = (k < 8);
            run_op((k < 8) ? BSF_IO_BIT_SET_OP : BSF_IO_BIT_CLEAR_OP, k[2:0], 8'h00, 2'b01);
            chk({io_waddr, io_wdata}, {5'h0a, e});
        end
        $display("t_io done");
    endtask : t_io
    task automatic t_bits;
        logic [7:0] r;
        for (int b = 0; b < 8; b++) begin
            fl[6] = b[0] ^ b[2];
            run_op(BSF_BIT_TO_FLAG_OP, b[2:0], {8{b[0] ^ b[2]}} ^ ~(8'h01 << b), 2'b00);
            r = 8'h3c;
            r[b] = fl[6];
            run_op(BSF_FLAG_TO_BIT_OP, b[2:0], 8'h3c, 2'b10);
            chk(res_data, r);
        end
        $display("t_bits done");
    endtask : t_bits
    task automatic t_flags;
        wr_flags(8'h5a);
        for (int s = 0; s < 8; s++) begin
            fl[s] = 1'b1;
            run_op(BSF_INDEXED_FLAG_SET_OP, s[2:0], 8'h00, 2'b00);
            fl[s] = 1'b0;
            run_op(BSF_INDEXED_FLAG_CLEAR_OP, s[2:0], 8'h00, 2'b00);
        end
        fl[7] = 1'b1;
        run_op(BSF_GLOBAL_IRQ_ENABLE_OP, 3'h0, 8'h00, 2'b00);
        fl[7] = 1'b0;
        run_op(BSF_GLOBAL_IRQ_DISABLE_OP, 3'h0, 8'h00, 2'b00);
        $display("t_flags done");
    endtask : t_flags
    // control ops, issue count, read-only and unmapped apb places
    task automatic t_ctrl;
        wr_flags(8'hbf);
        for (int k = 11; k < 14; k++) begin
            run_op(bsf_op_t'(k), 3'h0, 8'h00, 2'b00);
        end
        run_op(BSF_NOP, 3'h0, 8'h00, 2'b00);
        apb(1'b1, BSF_OFF_COUNT, 32'h0000_1234);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, BSF_OFF_COUNT, 32'h0);
        chk(rdv, {16'h0, n_ops[15:0]});
        chk({31'h0, err}, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(rdv, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, BSF_OFF_STATUS, 32'h0);
        chk(rdv, {24'h0, fl});
        $display("t_ctrl done");
    endtask : t_ctrl
    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk(status_flags, BSF_STATUS_RST);
        wr_flags(8'h00);
        t_shift;
        t_io;
        t_bits;
        t_flags;
        t_ctrl;
        results;
    end
endmodule : bsf_execute_tb
